// >>> src/adcctl_top.v
// converter channel routing, clock select, trigger and sequencing control
// Overview of operation
// - codes 0-15 route gated pin channels
// - codes 16-21 tie to low reference
// - reserved codes give undefined result
// - temp sensor 26, bandgap 27 needs buffer
// - all-ones select turns converter off
// - control write aborts, restarts conversion in software trigger mode
// - conversion clock from four sources
// - alternate clock divided by divide field
// - alternate clock unusable in stop three
// - hardware trigger on periodic counter overflow
// - trigger on first, then every second overflow
// - periodic counter from reference or 1 kHz
// - exactly two analog pin enable registers
// - right-justified 10 or 8 bit result
// - single and continuous, idle after single
// - compare less-than or greater-or-equal
// - complete flag with interrupt request
// - sample time and speed configurable
`timescale 1ns/1ps
`include "adcctl_consts.vh"
module adcctl_top (
	// system
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// clocks and power state
	input wire ext_ref_clk_en_i,
	input wire local_async_tick_i,
	input wire low_power_stop_level_three_i,
	// converter core
	input wire core_bit_i,
	output reg [4:0] analog_mux_sel_o,
	output reg [15:0] pin_analog_en_o,
	output reg conv_clk_en_o,
	output reg sample_o,
	output reg converter_on_o,
	output reg conv_irq_o
);
	localparam ST_IDLE = 2'd0;
	localparam ST_SAMP = 2'd1;
	localparam ST_CONV = 2'd2;
	reg [7:0] sc1_r;
	reg [3:0] sc2_r;
	reg [9:0] cmp_r;
	reg [7:0] cfg_r;
	reg [7:0] pina_r;
	reg [7:0] pinb_r;
	reg [1:0] pmc_r;
	reg [3:0] rti_r;
	reg [9:0] res_r;
	reg [9:0] sar_r;
	reg [1:0] st_r;
	reg [4:0] cnt_r;
	reg [15:0] khz_r;
	reg [14:0] rti_cnt_r;
	reg rti_out_r;
	reg [2:0] div_r;
	reg half_r;
	reg busy_r;
	wire wr = cyc_i & stb_i & we_i & ack_o & sel_i[0];
	wire rd = cyc_i & stb_i & ~we_i & ~ack_o;
	wire coco = sc1_r[7];
	wire aien = sc1_r[6];
	wire cont = sc1_r[5];
	wire [4:0] ch = sc1_r[4:0];
	wire ch_off = (ch == `ADC_CH_OFF);
	wire hwt_en = sc2_r[3];
	wire cmp_en = sc2_r[2];
	wire cmp_ge = sc2_r[1];
	wire mode8 = cfg_r[3];
	wire lsmp = cfg_r[4];
	wire lpwr = cfg_r[7];
	wire [1:0] clksel = cfg_r[1:0];
	wire [1:0] cdiv = cfg_r[6:5];
	wire sc1_wr = wr & (adr_i == `ADC_OFF_SC1);
	wire res_rd = rd & (adr_i == `ADC_OFF_RES);
	// write strobes, taken on the acknowledge edge
	wire sc2_wr = wr & (adr_i == `ADC_OFF_SC2);
	wire cmp_wr = wr & (adr_i == `ADC_OFF_CMP);
	wire cfg_wr = wr & (adr_i == `ADC_OFF_CFG);
	wire pina_wr = wr & (adr_i == `ADC_OFF_PINA);
	wire pinb_wr = wr & (adr_i == `ADC_OFF_PINB);
	wire pmc_wr = wr & (adr_i == `ADC_OFF_PMC);
	wire rti_wr = wr & (adr_i == `ADC_OFF_RTI);
	// channel and mode as they stand after this write
	wire [4:0] ch_new = sc1_wr ? dat_i[4:0] : ch;
	wire off_new = (ch_new == `ADC_CH_OFF);
	wire cont_new = sc1_wr ? dat_i[5] : cont;
	// source clock tick
	wire alt_ok = ext_ref_clk_en_i & ~low_power_stop_level_three_i;
	reg src_tick;
	always @* begin
		case (clksel)
			`ADC_CLK_BUS: src_tick = 1'b1;
			`ADC_CLK_BUS2: src_tick = half_r;
			`ADC_CLK_ALT: src_tick = alt_ok;
			`ADC_CLK_ASYNC: src_tick = local_async_tick_i;
			default: src_tick = 1'b0;
		endcase
	end
	// divide and power trade-off
	reg [2:0] div_max;
	always @* begin
		case (cdiv)
			2'h0: div_max = 3'h0;
			2'h1: div_max = 3'h1;
			2'h2: div_max = 3'h3;
			default: div_max = 3'h7;
		endcase
	end
	wire div_hit = (div_r >= div_max);
	wire conv_tick = src_tick & div_hit & (~lpwr | half_r);
	always @(posedge clk_i) begin
		if (rst_i)
			half_r <= 1'b0;
		else
			half_r <= ~half_r;
	end
	always @(posedge clk_i) begin
		if (rst_i)
			div_r <= 3'h0;
		else if (src_tick)
			div_r <= div_hit ? 3'h0 : div_r + 3'd1;
	end
	// periodic wake-up counter on 1 kHz or reference
	wire khz_tick = (khz_r == `ADC_KHZ_DIV);
	wire rti_clk = rti_r[3] ? ext_ref_clk_en_i : khz_tick;
	wire [14:0] rti_top = 15'h7FFF >> (3'd7 - rti_r[2:0]);
	wire rti_ovf = rti_clk & (rti_cnt_r >= rti_top) & (rti_r[2:0] != 3'h0);
	wire hw_trigger_input = rti_ovf & ~rti_out_r;
	// 1 kHz prescaler
	always @(posedge clk_i) begin
		if (rst_i)
			khz_r <= 16'h0;
		else
			khz_r <= khz_tick ? 16'h0 : khz_r + 16'd1;
	end
	// periodic counter and its output level
	always @(posedge clk_i) begin
		if (rst_i) begin
			rti_cnt_r <= 15'h0;
			rti_out_r <= 1'b0;
		end else if (rti_clk) begin
			rti_cnt_r <= rti_ovf ? 15'h0 : rti_cnt_r + 15'd1;
			if (rti_ovf)
				rti_out_r <= ~rti_out_r;
		end
	end
	// start request and completion
	wire low_power_stop_level_three_ok = ~low_power_stop_level_three_i | (pmc_r == 2'b11);
	reg start;
	always @* begin
		start = 1'b0;
		if (~off_new & low_power_stop_level_three_ok) begin
			if (hwt_en)
				start = hw_trigger_input;
			else if (sc1_wr)
				start = 1'b1;
			else if (cont & ~busy_r & (st_r == ST_IDLE))
				start = 1'b1;
		end
	end
	wire done = (st_r == ST_CONV) & conv_tick & (cnt_r == 5'd1);
	wire [9:0] fin = mode8 ? {2'b00, sar_r[8:1]} : {sar_r[8:0], core_bit_i};
	wire fin_hit = cmp_ge ? (fin >= cmp_r) : (fin < cmp_r);
	wire set_coco = done & (~cmp_en | fin_hit);
	// conversion sequencer, next state
	reg [1:0] st_nxt;
	reg [4:0] cnt_nxt;
	reg [9:0] sar_nxt;
	reg busy_nxt;
	always @* begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sar_nxt = sar_r;
		busy_nxt = busy_r;
		if (sc1_wr & off_new) begin
			st_nxt = ST_IDLE;
			busy_nxt = 1'b0;
		end else if (start) begin
			st_nxt = ST_SAMP;
			busy_nxt = ~cont_new;
			cnt_nxt = lsmp ? `ADC_LONG_SAMPLE : `ADC_SHORT_SAMPLE;
			sar_nxt = 10'h0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					if (~cont)
						busy_nxt = 1'b0;
				end
				ST_SAMP: begin
					if (conv_tick) begin
						if (cnt_r == 5'd1) begin
							st_nxt = ST_CONV;
							cnt_nxt = `ADC_CONV_CYC;
						end else
							cnt_nxt = cnt_r - 5'd1;
					end
				end
				ST_CONV: begin
					if (conv_tick) begin
						sar_nxt = {sar_r[8:0], core_bit_i};
						cnt_nxt = cnt_r - 5'd1;
						if (cnt_r == 5'd1)
							st_nxt = ST_IDLE;
					end
				end
				default: st_nxt = ST_IDLE;
			endcase
		end
	end
	// register stage
	always @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			cnt_r <= 5'h0;
			sar_r <= 10'h0;
			res_r <= 10'h0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sar_r <= sar_nxt;
			busy_r <= busy_nxt;
			if (done)
				res_r <= fin;
		end
	end
	// registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			sc1_r <= `ADC_SC1_RST;
			sc2_r <= 4'h0;
			cmp_r <= 10'h0;
			cfg_r <= 8'h0;
			pina_r <= 8'h0;
			pinb_r <= 8'h0;
			pmc_r <= 2'h0;
			rti_r <= 4'h0;
		end else begin
			if (set_coco)
				sc1_r[7] <= 1'b1;
			else if (sc1_wr | res_rd)
				sc1_r[7] <= 1'b0;
			if (sc1_wr)
				sc1_r[6:0] <= dat_i[6:0];
			if (sc2_wr)
				sc2_r <= dat_i[3:0];
			if (cmp_wr)
				cmp_r <= dat_i[9:0];
			if (cfg_wr)
				cfg_r <= dat_i[7:0];
			if (pina_wr)
				pina_r <= dat_i[7:0];
			if (pinb_wr)
				pinb_r <= dat_i[7:0];
			if (pmc_wr)
				pmc_r <= dat_i[1:0];
			if (rti_wr)
				rti_r <= dat_i[3:0];
		end
	end
	// read data select
	reg [31:0] rd_word;
	always @* begin
		case (adr_i)
			`ADC_OFF_SC1: rd_word = {24'h0, coco, sc1_r[6:0]};
			`ADC_OFF_SC2: rd_word = {24'h0, busy_r | (st_r != ST_IDLE),
				3'h0, sc2_r};
			`ADC_OFF_RES: rd_word = {22'h0, res_r};
			`ADC_OFF_CMP: rd_word = {22'h0, cmp_r};
			`ADC_OFF_CFG: rd_word = {24'h0, cfg_r};
			`ADC_OFF_PINA: rd_word = {24'h0, pina_r};
			`ADC_OFF_PINB: rd_word = {24'h0, pinb_r};
			`ADC_OFF_PMC: rd_word = {30'h0, pmc_r};
			`ADC_OFF_RTI: rd_word = {28'h0, rti_r};
			default: rd_word = 32'h0;
		endcase
	end
	// bus answer
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			dat_o <= rd ? rd_word : 32'h0;
		end
	end
	// analog routing
	reg [4:0] mux_nxt;
	always @* begin
		if (ch <= `ADC_CH_PIN_LAST)
			mux_nxt = ch;
		else if (ch <= `ADC_CH_UNIMP_LAST)
			mux_nxt = `ADC_CH_LOW_REF_INPUT;
		else if (ch == `ADC_CH_BGAP & ~pmc_r[1])
			mux_nxt = `ADC_CH_RSV;
		else
			mux_nxt = ch;
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			analog_mux_sel_o <= `ADC_CH_OFF;
			conv_clk_en_o <= 1'b0;
			sample_o <= 1'b0;
			converter_on_o <= 1'b0;
			conv_irq_o <= 1'b0;
		end else begin
			analog_mux_sel_o <= mux_nxt;
			conv_clk_en_o <= conv_tick & (st_r != ST_IDLE);
			sample_o <= (st_r == ST_SAMP);
			converter_on_o <= ~ch_off & (st_r != ST_IDLE);
			conv_irq_o <= (coco | set_coco) & aien;
		end
	end
	// per-pin analog enables
	wire [15:0] pin_ctl = {pinb_r, pina_r};
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin
			always @(posedge clk_i) begin
				if (rst_i)
					pin_analog_en_o[gi] <= 1'b0;
				else
					pin_analog_en_o[gi] <= pin_ctl[gi];
			end
		end
	endgenerate
endmodule // adcctl_top

// >>> src/adcctl_consts.vh
// constants for the converter channel, clock and trigger control block
`ifndef ADCCTL_CONSTS_VH
`define ADCCTL_CONSTS_VH
`define ADC_OFF_SC1 8'h00
`define ADC_OFF_SC2 8'h04
`define ADC_OFF_RES 8'h08
`define ADC_OFF_CMP 8'h0C
`define ADC_OFF_CFG 8'h10
`define ADC_OFF_PINA 8'h14
`define ADC_OFF_PINB 8'h18
`define ADC_OFF_PMC 8'h1C
`define ADC_OFF_RTI 8'h20
`define ADC_SC1_RST 8'h1F
`define ADC_CH_PIN_LAST 5'h0F
`define ADC_CH_UNIMP_LAST 5'h15
`define ADC_CH_TEMP 5'h1A
`define ADC_CH_BGAP 5'h1B
`define ADC_CH_RSV 5'h1C
`define ADC_CH_HIGH_REF_INPUT 5'h1D
`define ADC_CH_LOW_REF_INPUT 5'h1E
`define ADC_CH_OFF 5'h1F
`define ADC_CLK_BUS 2'h0
`define ADC_CLK_BUS2 2'h1
`define ADC_CLK_ALT 2'h2
`define ADC_CLK_ASYNC 2'h3
`define ADC_LONG_SAMPLE 5'h14
`define ADC_SHORT_SAMPLE 5'h04
`define ADC_CONV_CYC 5'h0A
`define ADC_KHZ_DIV 16'h4E1F
`endif

// >>> dv/adcctl_sva.sv
// port assertions for the converter control block
`timescale 1ns/1ps
module adcctl_sva (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [31:0] dat_i,
	input wire ack_o,
	input wire [4:0] analog_mux_sel_o,
	input wire conv_clk_en_o,
	input wire sample_o,
	input wire converter_on_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("long ack");
	a_req_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack");
	a_wr_start: assert property (ack_o && we_i && adr_i == 8'h00
		&& dat_i[4:0] != 5'h1F |-> ##[0:3] sample_o) else $error("no start");
	a_wr_off: assert property (ack_o && we_i && adr_i == 8'h00
		&& dat_i[4:0] == 5'h1F |-> ##[1:3] !converter_on_o) else $error("on");
	a_off_quiet: assert property ((analog_mux_sel_o == 5'h1F) [*2]
		|-> !sample_o) else $error("busy while off");
	a_unimp_low: assert property (analog_mux_sel_o < 5'h10
		|| analog_mux_sel_o > 5'h15) else $error("unimp code");
	a_tick_on: assert property (conv_clk_en_o |-> converter_on_o)
		else $error("tick off");
	a_samp_on: assert property (sample_o |-> converter_on_o)
		else $error("sample off");
endmodule // adcctl_sva
bind adcctl_top adcctl_sva u_adcctl_sva (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.dat_i(dat_i), .ack_o(ack_o), .analog_mux_sel_o(analog_mux_sel_o),
	.conv_clk_en_o(conv_clk_en_o), .sample_o(sample_o),
	.converter_on_o(converter_on_o));

// >>> dv/adcctl_core_model.sv
// analog core stand-in driving the decision bit
`timescale 1ns/1ps
module adcctl_core_model (
	input wire clk_i,
	input wire on_i,
	output reg bit_o = 1'b0
);
	always @(posedge clk_i)
		bit_o <= on_i ? 1'b1 : ~bit_o;
endmodule // adcctl_core_model

// >>> dv/adcctl_top_tb.sv
// bench for the converter control block
`timescale 1ns/1ps
module adcctl_top_tb;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, s3 = 0, xr = 0;
	logic ack, cb, ck, smp, on, irq;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rdat, q;
	logic [4:0] mux;
	logic [15:0] pen;
	int n_mismatch = 0, checked = 0;
	always #25 clk = ~clk;
	adcctl_top u_adcctl_top (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wd),
		.dat_o(rdat), .ack_o(ack), .ext_ref_clk_en_i(xr),
		.local_async_tick_i(1'b0), .low_power_stop_level_three_i(s3), .core_bit_i(cb),
		.analog_mux_sel_o(mux), .pin_analog_en_o(pen), .conv_clk_en_o(ck),
		.sample_o(smp), .converter_on_o(on), .conv_irq_o(irq));
	adcctl_core_model u_adcctl_core_model (.clk_i(clk), .on_i(on), .bit_o(cb));
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t %h %h", $time, g, e);
		end
	endtask
	task settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'h0;
	endtask
	task conv(input logic [7:0] s);
		wb(1'b1, 8'h00, s);
		q = 0;
		for (int i = 0; i < 99 && q[7] !== 1'b1; i++)
			wb(1'b0, 8'h00, 0);
		chk(q[7], 1);
	endtask
	task t_regs;
		wb(1'b0, 8'h00, 0);
		chk(q, 32'h1F);
		wb(1'b0, 8'h40, 0);
		chk(q, 0);
		wb(1'b1, 8'h14, 32'hA5);
		wb(1'b1, 8'h18, 32'h3C);
		settle();
		chk(pen, 16'h3CA5);
	endtask
	task t_single;
		conv(8'h43);
		chk({irq, mux}, 6'h23);
		wb(1'b0, 8'h08, 0);
		chk(q, 32'h3FF);
		wb(1'b0, 8'h04, 0);
		chk({q[7], irq}, 0);
		wb(1'b1, 8'h10, 32'h08);
		conv(8'h0F);
		wb(1'b0, 8'h08, 0);
		chk(q, 32'hFF);
		wb(1'b1, 8'h10, 0);
	endtask
	task t_mux;
		wb(1'b1, 8'h00, 32'h1B);
		settle();
		chk(mux, 5'h1C);
		wb(1'b1, 8'h00, 32'h1D);
		settle();
		chk(mux, 5'h1D);
		wb(1'b1, 8'h1C, 32'h02);
		wb(1'b1, 8'h00, 32'h1B);
		settle();
		chk(mux, 5'h1B);
	endtask
	task t_off;
		wb(1'b1, 8'h0C, 32'h3FF);
		wb(1'b1, 8'h04, 32'h06);
		conv(8'h25);
		wb(1'b1, 8'h00, 32'h1F);
		repeat (60) @(posedge clk);
		wb(1'b0, 8'h00, 0);
		chk({q[29:0], on, smp}, 32'h7C);
	endtask
	task t_clk;
		xr <= 1'b1;
		wb(1'b1, 8'h10, 32'h22);
		conv(8'h01);
		wb(1'b1, 8'h1C, 32'h03);
		s3 <= 1'b1;
		wb(1'b1, 8'h00, 32'h01);
		repeat (40) @(posedge clk);
		wb(1'b0, 8'h04, 0);
		chk(q[7], 1);
		wb(1'b1, 8'h10, 0);
		conv(8'h01);
		{s3, xr} <= 2'h0;
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_single();
		t_mux();
		t_off();
		t_clk();
		final_report();
	end
	initial #1000000 begin
		n_mismatch++;
		final_report();
	end
endmodule // adcctl_top_tb
